// file: bench/dpl_link_sva.sv
// assertions on link and output codes
`timescale 1ns/1ps
module dpl_link_sva #(
  parameter int UP_CYCLES   = 20,
  parameter int DOWN_CYCLES = 5
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               sampleClk,
  input wire dpl_pkg::dpl_word_t sampleWord,
  input wire logic               sleepLevel,
  input wire logic               sleepOe,
  input wire dpl_pkg::dpl_word_t primaryCode,
  input wire dpl_pkg::dpl_word_t complementaryCode,
  input wire logic               outputValid,
  input wire logic               poweredDown
);
  import dpl_pkg::*;
  // slack covers the sleep line synchroniser
  localparam int DN_MAX = DOWN_CYCLES + 8;
  localparam int UP_MAX = UP_CYCLES + 8;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_code_complement: assert property (outputValid |-> complementaryCode == CODE_FULL - primaryCode)
    else $error("complement code wrong");
  a_off_zero: assert property (poweredDown |-> primaryCode == 0 && complementaryCode == 0 && !outputValid)
    else $error("codes not zero when off");
  // new code shows three cycles after the rise is seen; at two cycles per word a check two cycles later sees the next word
  a_update_word: assert property (($rose(sampleClk) && outputValid) ##1 outputValid[*3]
    |-> primaryCode == $past(sampleWord, 3))
    else $error("output code not the latched word");
  // released sleep line must leave the device running
  a_float_awake: assert property (!sleepOe[*4] |-> !poweredDown)
    else $error("device asleep with sleep line released");
  a_word_stable: assert property ($rose(sampleClk) |-> $stable(sampleWord))
    else $error("word moved at clock rise");
  a_sleep_enter: assert property ($rose(sleepLevel) |-> ##[1:4] !outputValid)
    else $error("sleep ignored");
  a_down_bound: assert property ($rose(sleepLevel) |-> ##[1:DN_MAX] poweredDown)
    else $error("power-down too slow");
  a_wake_hold: assert property ($fell(sleepLevel) && poweredDown |-> !outputValid[*8])
    else $error("output valid too early");
  a_wake_bound: assert property ($fell(sleepLevel) && poweredDown |-> ##[UP_CYCLES:UP_MAX] outputValid)
    else $error("power-up too slow");
  c_update: cover property ($rose(sampleClk) && outputValid);
  c_off: cover property ($rose(poweredDown));
  c_wake: cover property ($rose(outputValid));
endmodule : dpl_link_sva

// file: bench/tb_top.sv
// bench joining source and device ends
`timescale 1ns/1ps
module tb_top;
  import dpl_pkg::*;
  logic      clk = 0;
  logic      rst = 1;
  dpl_word_t wordIn = '0;
  logic      wordValid = 0;
  logic      wordReady;
  logic      sleepReq = 0;
  dpl_word_t primaryCode;
  dpl_word_t complementaryCode;
  logic      outputValid;
  logic      poweredDown;
  logic      watch = 0;
  logic      full = 0;
  dpl_word_t prevCode = '0;
  dpl_word_t want;
  dpl_word_t exp[$];
  int        err_count = 0;
  int        checks = 0;
  int        cyc = 0;
  always #10 clk = ~clk;
  dpl_link_if i_dpl_link_if();
  dpl_source i_dpl_source (.clk(clk), .rst(rst), .wordIn(wordIn), .wordValid(wordValid),
    .wordReady(wordReady), .sleepReq(sleepReq), .link(i_dpl_link_if.source));
  // short power timings keep the run brief
  dpl_device #(.UP_CYCLES(20), .DOWN_CYCLES(5)) i_dpl_device (.clk(clk), .rst(rst),
    .link(i_dpl_link_if.device), .primaryCode(primaryCode), .complementaryCode(complementaryCode),
    .outputValid(outputValid), .poweredDown(poweredDown));
  dpl_link_sva #(.UP_CYCLES(20), .DOWN_CYCLES(5)) i_dpl_link_sva (.clk(clk), .rst(rst),
    .sampleClk(i_dpl_link_if.sampleClk), .sampleWord(i_dpl_link_if.sampleWord),
    .sleepLevel(i_dpl_link_if.sleepLevel), .sleepOe(i_dpl_link_if.sleepOe), .primaryCode(primaryCode),
    .complementaryCode(complementaryCode), .outputValid(outputValid), .poweredDown(poweredDown));
  task automatic chk(input dpl_word_t got, input dpl_word_t exv);
    checks++;
    if (got !== exv) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exv);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // valid stays up between words, so it is never set twice in one step
  task automatic push(input dpl_word_t w);
    logic ready;
    wordIn = w;
    wordValid = 1;
    // ready only moves on an edge, so the level seen between edges is the one the next edge takes
    do begin
      ready = wordReady;
      @(posedge clk);
    end while (!ready);
    #1;
  endtask : push
  // each new output code must be the next word sent
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wordValid && !wordReady) full <= 1;
    if (watch && outputValid && primaryCode !== prevCode) begin
      prevCode <= primaryCode;
      want = exp.size() ? exp.pop_front() : 8'h00;
      chk(primaryCode, want);
      chk(complementaryCode, CODE_FULL - want);
    end
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  // words at full rate overrun the link rate, so the fifo fills
  task automatic t_stream();
    watch = 1;
    for (int k = 0; k < 40; k++) begin
      exp.push_back(8'h80 + 8'h25 * k[7:0]);
      push(8'h80 + 8'h25 * k[7:0]);
    end
    wordValid = 0;
    chk(dpl_word_t'(full), 8'h01);
    for (int i = 0; i < 300 && exp.size() > 0; i++) @(posedge clk);
    chk(8'(exp.size()), 8'h00);
    $display("stream test done");
  endtask : t_stream
  // a word sent while off must show after wake-up
  task automatic t_sleep();
    watch = 0;
    @(posedge clk);
    #1 sleepReq = 1;
    for (int i = 0; i < 100 && !poweredDown; i++) @(posedge clk);
    #1;
    chk(dpl_word_t'(poweredDown), 8'h01);
    chk(primaryCode, 8'h00);
    chk(complementaryCode, 8'h00);
    push(8'h5A);
    wordValid = 0;
    repeat (10) @(posedge clk);
    #1 sleepReq = 0;
    for (int i = 0; i < 100 && !outputValid; i++) @(posedge clk);
    @(posedge clk);
    #1;
    chk(dpl_word_t'(outputValid), 8'h01);
    chk(primaryCode, 8'h5A);
    chk(complementaryCode, 8'hA5);
    $display("sleep test done");
  endtask : t_sleep
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    t_stream();
    t_sleep();
    results();
  end
endmodule : tb_top

// file: rtl/dpl_device.sv
// converter front end: latch on rising sample clock, sleep sequencing, output codes
`timescale 1ns/1ps
module dpl_device #(
  parameter int unsigned UP_CYCLES   = dpl_pkg::UP_CYC,
  parameter int unsigned DOWN_CYCLES = dpl_pkg::DOWN_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  dpl_link_if.device              link,
  output dpl_pkg::dpl_word_t      primaryCode,
  output dpl_pkg::dpl_word_t      complementaryCode,
  output logic                    outputValid,
  output logic                    poweredDown
);
  import dpl_pkg::*;
  logic       sClk1_r, sClk2_r, sClkPrev_r;
  dpl_word_t  sWord1_r, sWord2_r;
  logic       sSlp1_r, sSlp2_r;
  dpl_word_t  latched_r;
  dpl_word_t  primary_r, compl_r;
  logic       valid_r, down_r;
  dpl_pwr_t   pwr_r, pwr_nxt;
  logic [31:0] cnt_r;
  logic       rise;
  // two-stage synchronisers; only stage two is read
  always_ff @(posedge clk) begin
    if (rst) begin
      sClk1_r <= 1'b0; sClk2_r <= 1'b0; sClkPrev_r <= 1'b0;
      sWord1_r <= CODE_RST; sWord2_r <= CODE_RST;
      sSlp1_r <= 1'b0; sSlp2_r <= 1'b0;
    end else begin
      sClk1_r <= link.sampleClk;
      sClk2_r <= sClk1_r;
      sClkPrev_r <= sClk2_r;
      sWord1_r <= link.sampleWord;
      sWord2_r <= sWord1_r;
      sSlp1_r <= link.sleepLevel;  // RL7
      sSlp2_r <= sSlp1_r;
    end
  end
  // word skews with clock, so it is stable by the delayed rising edge
  assign rise = sClk2_r && !sClkPrev_r;
  // edge-triggered capture, keeps running in sleep
  always_ff @(posedge clk) begin
    if (rst) latched_r <= CODE_RST;
    else if (rise) latched_r <= sWord2_r;  // RL2 RL3 RL10
  end
  // power sequencing
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      PWR_ON:   if (sSlp2_r) pwr_nxt = PWR_DOWN;  // RL6
      PWR_DOWN: if (cnt_r >= DOWN_CYCLES - 1) pwr_nxt = PWR_OFF;  // RL8
      PWR_OFF:  if (!sSlp2_r) pwr_nxt = PWR_UP;
      PWR_UP:   if (sSlp2_r) pwr_nxt = PWR_DOWN;
                else if (cnt_r >= UP_CYCLES - 1) pwr_nxt = PWR_ON;  // RL8
      default:  pwr_nxt = PWR_ON;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) pwr_r <= PWR_ON;
    else     pwr_r <= pwr_nxt;
  end
  // counter restarts on every state change
  always_ff @(posedge clk) begin
    if (rst || pwr_nxt != pwr_r) cnt_r <= '0;
    else cnt_r <= cnt_r + 32'h0000_0001;
  end
  // outputs: zero current when off, codes held while powering down or up
  always_ff @(posedge clk) begin
    if (rst) begin
      primary_r <= CODE_RST; compl_r <= CODE_RST;
      valid_r <= 1'b0; down_r <= 1'b0;
    end else begin
      valid_r <= (pwr_nxt == PWR_ON);
      down_r  <= (pwr_nxt == PWR_OFF);
      if (pwr_nxt == PWR_ON) begin
        primary_r <= rise ? sWord2_r : latched_r;              // RL9
        compl_r   <= CODE_FULL - (rise ? sWord2_r : latched_r); // RL9
      end else if (pwr_nxt == PWR_OFF) begin
        primary_r <= CODE_RST;  // RL6
        compl_r   <= CODE_RST;
      end
    end
  end
  assign primaryCode       = primary_r;
  assign complementaryCode = compl_r;
  assign outputValid       = valid_r;
  assign poweredDown       = down_r;
endmodule : dpl_device

// file: rtl/dpl_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module dpl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  // storage written only on accepted words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
  // pointers wrap since depth is a power of two
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop)  rdPtr_r <= rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dpl_fifo

// file: rtl/dpl_link_if.sv
// link between sample source and converter front end
`timescale 1ns/1ps
interface dpl_link_if;
  import dpl_pkg::*;
  logic      sampleClk;   // sample strobe level, sampled by device
  dpl_word_t sampleWord;  // sample_bit_msb at bit 7, sample_bit_lsb at bit 0
  logic      sleepDrv;    // sleep driven level
  logic      sleepOe;     // source drives sleep
  logic      sleepLevel;  // resolved level with pull-down
  assign sleepLevel = sleepOe ? sleepDrv : 1'b0;  // RL7
  modport source (output sampleClk, output sampleWord, output sleepDrv, output sleepOe);
  modport device (input sampleClk, input sampleWord, input sleepLevel);
endinterface : dpl_link_if

// file: rtl/dpl_pkg.sv
// shared constants and types for the parallel sample latch converter front end
// How it works
// RL1 - eight-bit straight binary sample word
// RL2 - capture word in edge-triggered register
// RL3 - output updates only after rising clock
// RL4 - sample rate at most 125 MSPS
// RL5 - source keeps both clock phases wide enough
// RL6 - sleep high powers down, low runs
// RL7 - sleep input pulled low when undriven
// RL8 - down under 5 us, up 3.25 ms
// RL9 - outputs are code and 255 minus code
// RL10 - latch keeps capturing during sleep
package dpl_pkg;
  localparam int unsigned SAMPLE_W       = 8;
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned MAX_RATE_SPS   = 125_000_000;
  localparam int unsigned DOWN_TIME_NS   = 5_000;     // longest power-down time
  localparam int unsigned UP_TIME_US     = 3_250;     // power-up time, 3.25 ms
  // longest time rounds down, least time is whole microseconds times clock MHz with no rounding up
  localparam int unsigned DOWN_CYC       = (DOWN_TIME_NS * (CLK_HZ / 1_000_000)) / 1_000;
  localparam int unsigned UP_CYC         = (UP_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned FIFO_DEPTH     = 16;
  localparam logic [7:0]  CODE_FULL      = 8'hFF;
  localparam logic [7:0]  CODE_RST       = 8'h00;
  typedef logic [SAMPLE_W-1:0] dpl_word_t;
  typedef enum logic [3:0] {
    PWR_ON   = 4'b0001,
    PWR_DOWN = 4'b0010,
    PWR_OFF  = 4'b0100,
    PWR_UP   = 4'b1000
  } dpl_pwr_t;
endpackage : dpl_pkg

// file: rtl/dpl_source.sv
// sample source end: drains a fifo onto the parallel link
`timescale 1ns/1ps
module dpl_source #(
  parameter int unsigned DEPTH = dpl_pkg::FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire dpl_pkg::dpl_word_t wordIn,
  input  wire logic              wordValid,
  output logic                   wordReady,
  input  wire logic              sleepReq,
  dpl_link_if.source             link
);
  import dpl_pkg::*;
  dpl_word_t fData;
  logic      fValid;
  logic      phase_r;
  logic      clk_r;
  dpl_word_t word_r;
  logic      sleep_r;
  // one word per two cycles: 25 MSPS, below the 125 MSPS ceiling, both phases one cycle wide
  dpl_fifo #(.WIDTH(SAMPLE_W), .DEPTH(DEPTH)) uFifo (
    .clk      (clk),
    .rst      (rst),
    .inData   (wordIn),
    .inValid  (wordValid),
    .inReady  (wordReady),
    .outData  (fData),
    .outValid (fValid),
    .outReady (!phase_r && fValid)
  );
  // data set up on low phase, rising edge next cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= 1'b0;
      clk_r   <= 1'b0;
      word_r  <= CODE_RST;
    end else if (!phase_r) begin
      clk_r <= 1'b0;
      if (fValid) begin
        word_r  <= fData;  // RL1
        phase_r <= 1'b1;
      end
    end else begin
      clk_r   <= 1'b1;     // RL4 RL5
      phase_r <= 1'b0;
    end
  end
  // sleep request registered so the pin changes only after a clock edge
  always_ff @(posedge clk) begin
    if (rst) sleep_r <= 1'b0;
    else     sleep_r <= sleepReq;  // RL6
  end
  assign link.sampleClk  = clk_r;
  assign link.sampleWord = word_r;
  // pin only ever driven high; released while running, so the device pull-down must keep it low
  assign link.sleepDrv   = 1'b1;
  assign link.sleepOe    = sleep_r;  // RL6 RL7
endmodule : dpl_source
